// ===== verilog/pin_mux_consts.svh
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// Pad output value and enable while in reset
`define PM_RST_OUT 1'h0
`define PM_RST_OE 1'h0
// Level that an unselected function sees on its input
`define PM_IDLE_IN 1'h0
// Pads come up pulled high, so synchronisers reset high
`define PM_SYNC_RST 1'h1

`endif

// ===== verilog/pin_mux_pkg.sv
package pin_mux_pkg;
  // Function carried by one pad
  typedef enum logic [1:0] {
    FN_GPIO,
    FN_SPI_DATA,
    FN_TIMER,
    FN_PWM_SRC
  } pad_func_e;
endpackage

// ===== verilog/pad_route.sv
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module pad_route
  import pin_mux_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire pad_func_e sel, // Registered function select
  input wire logic gpioOut, // Port output value
  input wire logic gpioOe, // Port direction, high drives
  input wire logic spiOut, // Serial data value
  input wire logic spiOe, // Serial data drive enable
  input wire logic tmrOut, // Timer channel value
  input wire logic tmrOe, // Timer channel drive enable
  input wire logic padIn, // Synchronised pad level
  output logic padOut, // Pad output value
  output logic padOe, // Pad output enable
  output logic gpioIn, // Pad level to port logic
  output logic spiIn, // Pad level to serial unit
  output logic tmrIn, // Pad level to timer
  output logic pwmIn // Pad level to PWM source
);

  // True when the pad carries the given function
  function automatic logic picks(input pad_func_e s, input pad_func_e f);
    picks = (s == f);
  endfunction

  logic next_padOut; // Value chosen from the one source
  logic next_padOe; // Enable chosen from the one source

  // One source drives; PWM source is input only
  assign next_padOut = picks(sel, FN_SPI_DATA) ? spiOut :
                       picks(sel, FN_TIMER) ? tmrOut :
                       picks(sel, FN_GPIO) ? gpioOut : `PM_RST_OUT;
  assign next_padOe = picks(sel, FN_SPI_DATA) ? spiOe :
                      picks(sel, FN_TIMER) ? tmrOe :
                      picks(sel, FN_GPIO) ? gpioOe : `PM_RST_OE;

  // Unselected functions see the idle level
  assign gpioIn = picks(sel, FN_GPIO) ? padIn : `PM_IDLE_IN;
  assign spiIn = picks(sel, FN_SPI_DATA) ? padIn : `PM_IDLE_IN;
  assign tmrIn = picks(sel, FN_TIMER) ? padIn : `PM_IDLE_IN;
  assign pwmIn = picks(sel, FN_PWM_SRC) ? padIn : `PM_IDLE_IN;

  // Registered pad drive, so the pad never glitches on select changes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      padOut <= `PM_RST_OUT;
      padOe <= `PM_RST_OE;
    end else begin
      padOut <= next_padOut;
      padOe <= next_padOe;
    end
  end

endmodule

// ===== verilog/port_b_spi_data_pin_mux.sv
// Notes on behaviour
// - Each pad is port input or output
// - Reset selects port function on both pads
// - Slave-out pad: input as master, output as slave
// - Unselected slave leaves slave-out line undriven
// - Slave data leads master sample by half-period
// - Master-out pad: output as master, input as slave
// - Master data leads slave sample by half-period
// - Pad two feeds PWM pair four/five source
// - Pad three feeds PWM pair two/three source
// - Pad two carries timer A channel two
// - Pad three carries timer A channel three
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module port_b_spi_data_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic arst_n, // Async reset, active low
  // Function selects from the system integration unit
  input wire pad_func_e selPadTwo, // Function for pad two
  input wire pad_func_e selPadThree, // Function for pad three
  // Port logic
  input wire logic gpioTwoOut, // Port value for pad two
  input wire logic gpioTwoOe, // Port direction for pad two
  input wire logic gpioThreeOut, // Port value for pad three
  input wire logic gpioThreeOe, // Port direction for pad three
  output logic gpioTwoIn, // Pad two level to port
  output logic gpioThreeIn, // Pad three level to port
  // Serial peripheral unit zero
  input wire logic spiMaster, // High when serial unit is master
  input wire logic spiSlaveSelActive, // High when this slave is selected
  input wire logic spiSlaveOut, // Data sent as slave
  input wire logic spiMasterOut, // Data sent as master
  output logic spiMasterIn, // Data received as master
  output logic spiSlaveIn, // Data received as slave
  // Timer A channels two and three
  input wire logic tmrTwoOut, // Channel two output value
  input wire logic tmrTwoOe, // Channel two drive enable
  input wire logic tmrThreeOut, // Channel three output value
  input wire logic tmrThreeOe, // Channel three drive enable
  output logic tmrTwoIn, // Channel two capture input
  output logic tmrThreeIn, // Channel three capture input
  // External PWM sources
  output logic extPwmSourceZero, // Source for PWM pair four/five
  output logic extPwmSourceOne, // Source for PWM pair two/three
  // Pads
  input wire logic padTwoIn, // Pad two level from pin
  output logic padTwoOut, // Pad two output value
  output logic padTwoOe, // Pad two output enable
  input wire logic padThreeIn, // Pad three level from pin
  output logic padThreeOut, // Pad three output value
  output logic padThreeOe // Pad three output enable
);

  pad_func_e selTwo; // Held select for pad two
  pad_func_e selThree; // Held select for pad three
  logic twoMeta; // First synchroniser stage, pad two
  logic twoSync; // Second stage, safe to use
  logic threeMeta; // First synchroniser stage, pad three
  logic threeSync; // Second stage, safe to use
  logic spiTwoOe; // Slave-out drive enable
  logic spiThreeOe; // Master-out drive enable
  logic spiTwoRaw; // Pad two level when serial selected
  logic spiThreeRaw; // Pad three level when serial selected

  // Selects held in flops so reset forces the port function
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      selTwo <= FN_GPIO;
      selThree <= FN_GPIO;
    end else begin
      selTwo <= selPadTwo;
      selThree <= selPadThree;
    end
  end

  // Pins are asynchronous; two stages before any logic reads them
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      twoMeta <= `PM_SYNC_RST;
      twoSync <= `PM_SYNC_RST;
      threeMeta <= `PM_SYNC_RST;
      threeSync <= `PM_SYNC_RST;
    end else begin
      twoMeta <= padTwoIn;
      twoSync <= twoMeta;
      threeMeta <= padThreeIn;
      threeSync <= threeMeta;
    end
  end

  // Slave drives only while selected, master never drives
  assign spiTwoOe = !spiMaster && spiSlaveSelActive;
  // Master drives, slave listens
  assign spiThreeOe = spiMaster;

  // Incoming serial data goes only to the role that listens on that pad
  assign spiMasterIn = spiMaster ? spiTwoRaw : `PM_IDLE_IN;
  assign spiSlaveIn = spiMaster ? `PM_IDLE_IN : spiThreeRaw;

  // Pad two: port, slave-out, timer channel two, PWM source zero
  // Edge placement of serial data is the serial unit's; the mux adds
  // one system clock, far below half a serial period
  pad_route uPadTwo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sel(selTwo),
    .gpioOut(gpioTwoOut),
    .gpioOe(gpioTwoOe),
    .spiOut(spiSlaveOut),
    .spiOe(spiTwoOe),
    .tmrOut(tmrTwoOut),
    .tmrOe(tmrTwoOe),
    .padIn(twoSync),
    .padOut(padTwoOut),
    .padOe(padTwoOe),
    .gpioIn(gpioTwoIn),
    .spiIn(spiTwoRaw),
    .tmrIn(tmrTwoIn),
    .pwmIn(extPwmSourceZero)
  );

  // Pad three: port, master-out, timer channel three, PWM source one
  // Same single-clock latency applies to master data
  pad_route uPadThree (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sel(selThree),
    .gpioOut(gpioThreeOut),
    .gpioOe(gpioThreeOe),
    .spiOut(spiMasterOut),
    .spiOe(spiThreeOe),
    .tmrOut(tmrThreeOut),
    .tmrOe(tmrThreeOe),
    .padIn(threeSync),
    .padOut(padThreeOut),
    .padOe(padThreeOe),
    .gpioIn(gpioThreeIn),
    .spiIn(spiThreeRaw),
    .tmrIn(tmrThreeIn),
    .pwmIn(extPwmSourceOne)
  );

  // Checks, all in the system clock domain
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  a_port_pad_two: assert property (
    selTwo == FN_GPIO |=> padTwoOe == $past(gpioTwoOe) && padTwoOut == $past(gpioTwoOut)
  ) else $error("pad two does not follow port drive");

  a_reset_port_select: assert property (
    $rose(arst_n) |-> selTwo == FN_GPIO && selThree == FN_GPIO && !padTwoOe && !padThreeOe
  ) else $error("port function not selected after reset");

  a_miso_master_input: assert property (
    selTwo == FN_SPI_DATA && spiMaster |=> !padTwoOe
  ) else $error("slave-out pad driven while master");

  a_miso_unselected_hiz: assert property (
    selTwo == FN_SPI_DATA && !spiSlaveSelActive |=> !padTwoOe
  ) else $error("slave-out pad driven while not selected");

  a_miso_slave_data: assert property (
    selTwo == FN_SPI_DATA && !spiMaster && spiSlaveSelActive
      |=> padTwoOe && padTwoOut == $past(spiSlaveOut)
  ) else $error("slave data not on slave-out pad");

  a_mosi_direction: assert property (
    selThree == FN_SPI_DATA |=> padThreeOe == $past(spiMaster)
  ) else $error("master-out pad direction wrong");

  a_mosi_master_data: assert property (
    selThree == FN_SPI_DATA && spiMaster |=> padThreeOut == $past(spiMasterOut)
  ) else $error("master data not on master-out pad");

  a_pwm_pair_four: assert property (
    selTwo == FN_PWM_SRC |-> extPwmSourceZero == twoSync ##1 !padTwoOe
  ) else $error("PWM source zero not fed from pad two");

  a_pwm_pair_two: assert property (
    selThree == FN_PWM_SRC |-> extPwmSourceOne == threeSync ##1 !padThreeOe
  ) else $error("PWM source one not fed from pad three");

  a_timer_chan_two: assert property (
    selTwo == FN_TIMER |-> tmrTwoIn == twoSync ##1 padTwoOe == $past(tmrTwoOe)
  ) else $error("timer channel two not on pad two");

  a_timer_chan_three: assert property (
    selThree == FN_TIMER |-> tmrThreeIn == threeSync ##1 padThreeOut == $past(tmrThreeOut)
  ) else $error("timer channel three not on pad three");

  a_idle_unselected: assert property (
    selTwo != FN_GPIO |-> gpioTwoIn == `PM_IDLE_IN && (selTwo == FN_PWM_SRC || extPwmSourceZero == `PM_IDLE_IN)
  ) else $error("unselected function sees pad two");

  a_port_pad_three: assert property (
    selThree == FN_GPIO |=> padThreeOe == $past(gpioThreeOe) && padThreeOut == $past(gpioThreeOut)
  ) else $error("pad three does not follow port drive");

  a_master_in_data: assert property (
    selTwo == FN_SPI_DATA && spiMaster |-> spiMasterIn == twoSync
  ) else $error("master does not hear slave-out pad");

  a_slave_in_data: assert property (
    selThree == FN_SPI_DATA && !spiMaster |-> spiSlaveIn == threeSync
  ) else $error("slave does not hear master-out pad");

  a_master_in_gated: assert property (
    !(selTwo == FN_SPI_DATA && spiMaster) |-> spiMasterIn == `PM_IDLE_IN
  ) else $error("master input not idle while unselected");

  a_slave_in_gated: assert property (
    !(selThree == FN_SPI_DATA && !spiMaster) |-> spiSlaveIn == `PM_IDLE_IN
  ) else $error("slave input not idle while unselected");

  a_idle_pad_three: assert property (
    selThree != FN_GPIO |-> gpioThreeIn == `PM_IDLE_IN && (selThree == FN_PWM_SRC || extPwmSourceOne == `PM_IDLE_IN)
      && (selThree == FN_TIMER || tmrThreeIn == `PM_IDLE_IN)
  ) else $error("unselected function sees pad three");

endmodule

// ===== tb/spi_peer_model.sv
`timescale 1ns/1ps
module spi_peer_model (
  input wire logic peerEn, // Peer active
  input wire logic peerIsMaster, // Peer is serial master
  input wire logic peerBit, // Bit the peer puts out
  input wire logic padTwoOut, // Device value, pad two
  input wire logic padTwoOe, // Device enable, pad two
  input wire logic padThreeOut, // Device value, pad three
  input wire logic padThreeOe, // Device enable, pad three
  output logic padTwoLine, // Wire level, pad two
  output logic padThreeLine // Wire level, pad three
);
  logic drvTwo; // Peer drives slave-out line
  logic drvThree; // Peer drives master-out line
  // A slave peer drives slave-out only while active
  assign drvTwo = peerEn && !peerIsMaster;
  // A master peer drives master-out ahead of its sample edge
  assign drvThree = peerEn && peerIsMaster;
  // Pull-ups hold idle lines high; contention goes unknown so it cannot pass
  assign padTwoLine = (padTwoOe && drvTwo) ? 1'hx : padTwoOe ? padTwoOut : drvTwo ? peerBit : 1'h1;
  assign padThreeLine = (padThreeOe && drvThree) ? 1'hx : padThreeOe ? padThreeOut : drvThree ? peerBit : 1'h1;
endmodule

// ===== tb/port_b_spi_data_pin_mux_bench.sv
`timescale 1ns/1ps
module port_b_spi_data_pin_mux_bench
  import pin_mux_pkg::*;
;
  logic sys_clk = 1'h0, arst_n = 1'h0; // Clock and reset
  pad_func_e selPadTwo = FN_GPIO, selPadThree = FN_GPIO; // Selects
  logic gpioTwoOut = 0, gpioTwoOe = 0, gpioThreeOut = 0, gpioThreeOe = 0; // Port side
  logic spiMaster = 0, spiSlaveSelActive = 0, spiSlaveOut = 0, spiMasterOut = 0; // Serial side
  logic tmrTwoOut = 0, tmrTwoOe = 0, tmrThreeOut = 0, tmrThreeOe = 0; // Timer side
  logic peerEn = 0, peerIsMaster = 0, peerBit = 0; // Peer control
  logic gpioTwoIn, gpioThreeIn, spiMasterIn, spiSlaveIn, tmrTwoIn, tmrThreeIn; // Function inputs
  logic extPwmSourceZero, extPwmSourceOne, padTwoLine, padThreeLine; // PWM sources, wires
  logic padTwoOut, padTwoOe, padThreeOut, padThreeOe; // Pad drive
  int failures = 0, n_tests = 0; // Counters
  // Pad drive and all function inputs judged together as one vector
  wire [11:0] seen = {padTwoOe, padTwoOut, padThreeOe, padThreeOut, gpioTwoIn, gpioThreeIn,
    spiMasterIn, spiSlaveIn, tmrTwoIn, tmrThreeIn, extPwmSourceZero, extPwmSourceOne};
  always #10 sys_clk = ~sys_clk; // 50 MHz
  port_b_spi_data_pin_mux u_port_b_spi_data_pin_mux (.sys_clk(sys_clk), .arst_n(arst_n),
    .selPadTwo(selPadTwo), .selPadThree(selPadThree), .gpioTwoOut(gpioTwoOut), .gpioTwoOe(gpioTwoOe),
    .gpioThreeOut(gpioThreeOut), .gpioThreeOe(gpioThreeOe), .gpioTwoIn(gpioTwoIn),
    .gpioThreeIn(gpioThreeIn), .spiMaster(spiMaster), .spiSlaveSelActive(spiSlaveSelActive),
    .spiSlaveOut(spiSlaveOut), .spiMasterOut(spiMasterOut), .spiMasterIn(spiMasterIn),
    .spiSlaveIn(spiSlaveIn), .tmrTwoOut(tmrTwoOut), .tmrTwoOe(tmrTwoOe), .tmrThreeOut(tmrThreeOut),
    .tmrThreeOe(tmrThreeOe), .tmrTwoIn(tmrTwoIn), .tmrThreeIn(tmrThreeIn),
    .extPwmSourceZero(extPwmSourceZero), .extPwmSourceOne(extPwmSourceOne), .padTwoIn(padTwoLine),
    .padTwoOut(padTwoOut), .padTwoOe(padTwoOe), .padThreeIn(padThreeLine),
    .padThreeOut(padThreeOut), .padThreeOe(padThreeOe));
  spi_peer_model u_spi_peer_model (.peerEn(peerEn), .peerIsMaster(peerIsMaster), .peerBit(peerBit),
    .padTwoOut(padTwoOut), .padTwoOe(padTwoOe), .padThreeOut(padThreeOut), .padThreeOe(padThreeOe),
    .padTwoLine(padTwoLine), .padThreeLine(padThreeLine));
  // Falling edges only, so inputs never race the sampling edge
  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Counts: %0d mismatches in %0d comparisons", failures, n_tests);
    if (failures == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Port mode both ways; pad three driven low then high by the peer
  task automatic t_gpio();
    gpioTwoOe = 1; peerEn = 1; peerIsMaster = 1; step(3);
    chk(12'h800);
    gpioTwoOut = 1; peerBit = 1; step(3);
    chk(12'hcc0);
  endtask
  // Master then slave; stale port enable must not leak through
  task automatic t_spi();
    // Peer keeps off the lines for the two edges the pads need to turn round
    selPadTwo = FN_SPI_DATA; selPadThree = FN_SPI_DATA; spiMaster = 1; spiMasterOut = 1;
    spiSlaveSelActive = 1; peerEn = 0; peerBit = 0; step(2);
    peerEn = 1; peerIsMaster = 0; step(3);
    chk(12'h300);
    peerBit = 1; step(3);
    chk(12'h320);
    spiMaster = 0; spiSlaveOut = 1; spiMasterOut = 0; peerEn = 0; step(2);
    peerEn = 1; peerIsMaster = 1; step(3);
    chk(12'hc10);
    spiSlaveSelActive = 0; spiSlaveOut = 0; step(3);
    chk(12'h010);
  endtask
  // Each channel drives its pad while the other captures
  task automatic t_tmr();
    selPadTwo = FN_TIMER; selPadThree = FN_TIMER; tmrTwoOe = 1; tmrTwoOut = 1; peerBit = 0; step(3);
    chk(12'hc08);
    // Peer swaps roles only once pad two has stopped driving
    tmrTwoOe = 0; tmrTwoOut = 0; tmrThreeOe = 1; tmrThreeOut = 1; peerEn = 0; step(2);
    peerEn = 1; peerIsMaster = 0; step(3);
    chk(12'h304);
  endtask
  // PWM source pads never drive; each feeds its own pair
  task automatic t_pwm();
    // Pad three drives low until two edges after the select, then needs two more to sync
    tmrThreeOut = 0; gpioTwoOut = 0; selPadTwo = FN_PWM_SRC; selPadThree = FN_PWM_SRC; step(4);
    chk(12'h001);
    peerIsMaster = 1; step(3);
    chk(12'h002);
  endtask
  // Mid-run reset forces the port function although PWM is still requested
  task automatic t_reset();
    arst_n = 0; step(2);
    chk(12'h0c0);
    // Held port drive comes out for one edge after release, so allow the syncs to settle
    arst_n = 1; step(4);
    chk(12'h002);
  endtask
  initial begin
    step(12);
    chk(12'h0c0);
    arst_n = 1; step(3);
    chk(12'h0c0);
    t_gpio();
    t_spi();
    t_tmr();
    t_pwm();
    t_reset();
    close_out();
  end
  // Whole run needs about 60 cycles
  initial begin
    repeat (400) @(posedge sys_clk);
    failures++;
    close_out();
  end
endmodule
